// file: include/i2c_rx_client_pkg.sv
// constants, register layouts and state record of the two-wire receive and client block
package i2c_rx_client_pkg;

  // clock and host bit timing
  localparam int          CLK_MHZ      = 100;
  localparam int          HOST_HALF_NS = 5000;
  localparam int          HALF_CYC     = (HOST_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [9:0]  HALF_CNT     = 10'(HALF_CYC - 1);
  localparam logic [3:0]  BITS_BYTE    = 4'h8;

  // register byte addresses
  localparam logic [31:0] OFF_HCTLB = 32'h0000_0000;
  localparam logic [31:0] OFF_HSTAT = 32'h0000_0004;
  localparam logic [31:0] OFF_HDATA = 32'h0000_0008;
  localparam logic [31:0] OFF_CCTLA = 32'h0000_000C;
  localparam logic [31:0] OFF_CCTLB = 32'h0000_0010;
  localparam logic [31:0] OFF_CSTAT = 32'h0000_0014;
  localparam logic [31:0] OFF_TID   = 32'h0000_0018;
  localparam logic [31:0] OFF_MASK  = 32'h0000_001C;
  localparam logic [31:0] OFF_CBYTE = 32'h0000_0020;

  // host and client command field encodings
  localparam logic [1:0]  HCMD_REPST = 2'h1;
  localparam logic [1:0]  HCMD_RECV  = 2'h2;
  localparam logic [1:0]  HCMD_STOP  = 2'h3;
  localparam int          HCMD_LSB   = 1;
  localparam int          CCMD_BIT   = 1;

  // write-one-to-clear masks
  localparam logic [6:0]  HSTAT_W1C = 7'h1A;
  localparam logic [7:0]  CSTAT_W1C = 8'h33;

  typedef enum logic [1:0] {BUS_UNKNOWN, BUS_IDLE, BUS_BUSY, BUS_OWNER} bus_state_e;
  typedef enum logic [2:0] {H_IDLE, H_RX, H_HELD, H_ACK, H_STOP} host_st_e;
  typedef enum logic [3:0] {C_IDLE, C_ADDR, C_AHOLD, C_AACK, C_WR, C_DHOLD, C_DACK,
                            C_RD, C_RACK} cli_st_e;

  // host_status_reg layout
  typedef struct packed {
    bus_state_e bus_state;
    logic       fault;
    logic       arb;
    logic       stretch;
    logic       tx_done;
    logic       rx_flag;
  } hstat_s;

  // client_status_reg layout
  typedef struct packed {
    logic stretch;
    logic rxack;
    logic clash;
    logic fault;
    logic dir;
    logic cause;
    logic frame;
    logic byte_flag;
  } cstat_s;

  typedef struct packed {
    logic prom;
    logic en;
  } cctla_s;

  typedef struct packed {
    logic [6:0] second_target_id_field;
    logic       second_id_match_enable;
  } cmask_s;

  // whole state of the block
  typedef struct packed {
    logic        scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic        dph_valid;
    logic        dph_write;
    logic [31:0] dph_addr;
    logic [31:0] rdata;
    host_st_e    hst;
    logic [9:0]  tick_cnt;
    logic        hph;
    logic [3:0]  hbit;
    logic [7:0]  hshift;
    logic [7:0]  hdata;
    logic        h_scl_low;
    logic        h_sda_low;
    logic        h_rsel;
    logic [1:0]  h_cmd;
    hstat_s      hstat;
    cli_st_e     cst;
    logic [3:0]  cbit;
    logic [7:0]  cshift;
    logic        c_sda_low;
    logic        c_mute;
    logic        c_rsel;
    cctla_s      ccta;
    cstat_s      cstat;
    logic [7:0]  tid;
    cmask_s      cmask;
    logic [7:0]  cbyte;
  } state_s;

  localparam state_s ST_RST = '0;

endpackage

// file: rtl/i2c_rx_client.sv
// two-wire host byte receive path and client engine behind an AHB-Lite register slave
// Function
// - host releases SCL one byte, then flags
// - host drives reply only on command write
// - reply 0 gives ACK, 1 gives NACK
// - NACK collision loses bus, flags, Busy
// - loss or bus error sets tx done
// - rx byte and tx done exclusive
// - client has data, frame and status flags
// - frame or data flag stretches SCL low in a hold state
// - after Start shift address, store on match
// - no match: no ACK, byte unchanged
// - match own seven-bit identifier
// - general call matches when enabled
// - second identifier matches when enabled
// - promiscuous mode matches every address
// - Start then Stop sets bus fault
// - write direction reported, SCL stretched
// - read direction reported, data flag, stretch
// - Stop sets frame flag, cause zero
// - client collision flags, mutes, keeps Start
// - each written byte flags; reply on command
`timescale 1ns/1ps
module i2c_rx_client
  import i2c_rx_client_pkg::*;
(
  // clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        SYS_RST_IN,
  // AHB-Lite slave
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  // two-wire bus, open drain
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE_N_OUT,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N_OUT
);

  state_s st_r;
  state_s st_nxt;
  logic   tick;
  logic   scl_rise;
  logic   scl_fall;
  logic   start_det;
  logic   stop_det;
  logic   addr_hit;
  logic   c_hold;
  logic   wr_en;

  // exact word address decode
  function automatic logic reg_hit(input logic [31:0] a, input logic [31:0] off);
    reg_hit = (a == off);
  endfunction

  // bus edges and conditions from synchronised levels
  assign tick      = (st_r.tick_cnt == 10'h0);
  assign scl_rise  = st_r.scl_s & ~st_r.scl_d;
  assign scl_fall  = ~st_r.scl_s & st_r.scl_d;
  assign start_det = st_r.scl_s & st_r.scl_d & st_r.sda_d & ~st_r.sda_s;
  assign stop_det  = st_r.scl_s & st_r.scl_d & ~st_r.sda_d & st_r.sda_s;
  assign wr_en     = st_r.dph_valid & st_r.dph_write;

  // address match sources
  assign addr_hit = st_r.ccta.prom
                  | (st_r.cshift[7:1] == st_r.tid[7:1])
                  | ((st_r.cshift[7:1] == 7'h00) & st_r.tid[0])
                  | (st_r.cmask.second_id_match_enable
                     & (st_r.cshift[7:1] == st_r.cmask.second_target_id_field));

  // client stretches only while waiting on software with a flag up
  assign c_hold = ((st_r.cst == C_AHOLD) | (st_r.cst == C_DHOLD)) & ~st_r.c_mute
                & (st_r.cstat.frame | st_r.cstat.byte_flag);

  // pins and bus answer
  assign SCL_OUT       = 1'b0;
  assign SDA_OUT       = 1'b0;
  assign SCL_OE_N_OUT  = ~(st_r.h_scl_low | c_hold);
  assign SDA_OE_N_OUT  = ~(st_r.h_sda_low | (st_r.c_sda_low & ~st_r.c_mute));
  assign HRDATA_OUT    = st_r.rdata;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;

  // next-state logic
  always_comb begin
    logic       hcmd_go;
    logic [1:0] hcmd;
    logic       ccmd_go;
    hcmd_go = 1'b0;
    hcmd    = 2'h0;
    ccmd_go = 1'b0;
    st_nxt  = st_r;

    // synchronisers and edge history
    st_nxt.scl_m = SCL_IN;
    st_nxt.scl_s = st_r.scl_m;
    st_nxt.scl_d = st_r.scl_s;
    st_nxt.sda_m = SDA_IN;
    st_nxt.sda_s = st_r.sda_m;
    st_nxt.sda_d = st_r.sda_s;
    st_nxt.tick_cnt = tick ? HALF_CNT : st_r.tick_cnt - 10'h1;

    // address phase capture and registered read data
    st_nxt.dph_valid = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
    st_nxt.dph_write = HWRITE_IN;
    st_nxt.dph_addr  = HADDR_IN;
    st_nxt.rdata     = 32'h0;
    if (HSEL_IN & HTRANS_IN[1] & HREADY_IN & ~HWRITE_IN) begin
      case (HADDR_IN)
        OFF_HCTLB: st_nxt.rdata = {31'h0, st_r.h_rsel};
        OFF_HSTAT: st_nxt.rdata = {25'h0, st_r.hstat};
        OFF_HDATA: st_nxt.rdata = {24'h0, st_r.hdata};
        OFF_CCTLA: st_nxt.rdata = {30'h0, st_r.ccta};
        OFF_CCTLB: st_nxt.rdata = {31'h0, st_r.c_rsel};
        OFF_CSTAT: st_nxt.rdata = {24'h0, st_r.cstat};
        OFF_TID:   st_nxt.rdata = {24'h0, st_r.tid};
        OFF_MASK:  st_nxt.rdata = {24'h0, st_r.cmask};
        OFF_CBYTE: st_nxt.rdata = {24'h0, st_r.cbyte};
        default:   st_nxt.rdata = 32'h0;
      endcase
    end

    // data phase writes; clears come first so hardware sets win
    if (wr_en) begin
      if (reg_hit(st_r.dph_addr, OFF_HCTLB)) begin
        st_nxt.h_rsel = HWDATA_IN[0];
        hcmd          = HWDATA_IN[HCMD_LSB+:2];
        hcmd_go       = (hcmd != 2'h0);
      end
      if (reg_hit(st_r.dph_addr, OFF_HSTAT)) begin
        st_nxt.hstat = st_r.hstat & ~(HWDATA_IN[6:0] & HSTAT_W1C);
      end
      if (reg_hit(st_r.dph_addr, OFF_CCTLA)) begin
        st_nxt.ccta = HWDATA_IN[1:0];
      end
      if (reg_hit(st_r.dph_addr, OFF_CCTLB)) begin
        st_nxt.c_rsel = HWDATA_IN[0];
        ccmd_go       = HWDATA_IN[CCMD_BIT];
      end
      if (reg_hit(st_r.dph_addr, OFF_CSTAT)) begin
        st_nxt.cstat = st_r.cstat & ~(HWDATA_IN[7:0] & CSTAT_W1C);
      end
      if (reg_hit(st_r.dph_addr, OFF_TID)) begin
        st_nxt.tid = HWDATA_IN[7:0];
      end
      if (reg_hit(st_r.dph_addr, OFF_MASK)) begin
        st_nxt.cmask = HWDATA_IN[7:0];
      end
      if (reg_hit(st_r.dph_addr, OFF_CBYTE)) begin
        st_nxt.cbyte = HWDATA_IN[7:0];
      end
    end

    // tracked bus state from foreign conditions
    if (stop_det & (st_r.hst == H_IDLE)) begin
      st_nxt.hstat.bus_state = BUS_IDLE;
    end else if (start_det & (st_r.hst == H_IDLE) & (st_r.hstat.bus_state == BUS_IDLE)) begin
      st_nxt.hstat.bus_state = BUS_BUSY;
    end

    // host receive engine
    case (st_r.hst)
      H_IDLE: begin
        st_nxt.h_scl_low = 1'b0;
        st_nxt.h_sda_low = 1'b0;
        if (hcmd_go & (hcmd == HCMD_RECV)) begin
          st_nxt.hst             = H_RX;
          st_nxt.hbit            = 4'h0;
          st_nxt.hph             = 1'b0;
          st_nxt.h_scl_low       = 1'b1;
          st_nxt.hstat.bus_state = BUS_OWNER;
        end
      end
      H_RX: begin
        st_nxt.h_sda_low = 1'b0;
        if (tick & ~st_r.hph) begin
          st_nxt.hph       = 1'b1;
          st_nxt.h_scl_low = 1'b0;
        end else if (tick) begin
          st_nxt.hph       = 1'b0;
          st_nxt.h_scl_low = 1'b1;
          st_nxt.hshift    = {st_r.hshift[6:0], st_r.sda_s};
          st_nxt.hbit      = st_r.hbit + 4'h1;
          if (st_r.hbit == BITS_BYTE - 4'h1) begin
            st_nxt.hst           = H_HELD;
            st_nxt.hdata         = {st_r.hshift[6:0], st_r.sda_s};
            st_nxt.hstat.rx_flag = 1'b1;
            st_nxt.hstat.stretch = 1'b1;
            st_nxt.hstat.tx_done = 1'b0;
          end
        end
      end
      H_HELD: begin
        st_nxt.h_scl_low = 1'b1;
        if (hcmd_go) begin
          st_nxt.hst           = H_ACK;
          st_nxt.hph           = 1'b0;
          st_nxt.h_cmd         = hcmd;
          st_nxt.h_sda_low     = ~HWDATA_IN[0];
          st_nxt.hstat.rx_flag = 1'b0;
          st_nxt.hstat.stretch = 1'b0;
        end
      end
      H_ACK: begin
        if (tick & ~st_r.hph) begin
          st_nxt.hph       = 1'b1;
          st_nxt.h_scl_low = 1'b0;
        end else if (tick & st_r.h_rsel & ~st_r.sda_s) begin
          st_nxt.hst             = H_IDLE;
          st_nxt.h_scl_low       = 1'b0;
          st_nxt.hstat.arb       = 1'b1;
          st_nxt.hstat.tx_done   = 1'b1;
          st_nxt.hstat.rx_flag   = 1'b0;
          st_nxt.hstat.bus_state = BUS_BUSY;
        end else if (tick) begin
          st_nxt.hph       = 1'b0;
          st_nxt.h_scl_low = 1'b1;
          st_nxt.h_sda_low = 1'b0;
          st_nxt.hbit      = 4'h0;
          if (st_r.h_cmd == HCMD_STOP) begin
            st_nxt.hst       = H_STOP;
            st_nxt.h_sda_low = 1'b1;
          end else if ((st_r.h_cmd == HCMD_RECV) & ~st_r.h_rsel) begin
            st_nxt.hst = H_RX;
          end else begin
            st_nxt.hst       = H_IDLE;
            st_nxt.h_scl_low = 1'b0;
          end
        end
      end
      H_STOP: begin
        if (tick & ~st_r.hph) begin
          st_nxt.hph       = 1'b1;
          st_nxt.h_scl_low = 1'b0;
        end else if (tick) begin
          st_nxt.hst             = H_IDLE;
          st_nxt.h_sda_low       = 1'b0;
          st_nxt.hstat.bus_state = BUS_IDLE;
        end
      end
      default: st_nxt.hst = H_IDLE;
    endcase

    // bus error while receiving or replying
    if (((st_r.hst == H_RX) | (st_r.hst == H_ACK)) & (start_det | stop_det)) begin
      st_nxt.hst             = H_IDLE;
      st_nxt.h_scl_low       = 1'b0;
      st_nxt.h_sda_low       = 1'b0;
      st_nxt.hstat.fault     = 1'b1;
      st_nxt.hstat.arb       = 1'b1;
      st_nxt.hstat.tx_done   = 1'b1;
      st_nxt.hstat.rx_flag   = 1'b0;
      st_nxt.hstat.bus_state = BUS_BUSY;
    end

    // client engine
    case (st_r.cst)
      C_ADDR, C_WR: begin
        if (scl_rise) begin
          st_nxt.cshift = {st_r.cshift[6:0], st_r.sda_s};
          st_nxt.cbit   = st_r.cbit + 4'h1;
        end else if (scl_fall & (st_r.cbit == BITS_BYTE)) begin
          if (st_r.cst == C_WR) begin
            st_nxt.cst             = C_DHOLD;
            st_nxt.cbyte           = st_r.cshift;
            st_nxt.cstat.byte_flag = 1'b1;
          end else if (addr_hit) begin
            st_nxt.cst         = C_AHOLD;
            st_nxt.cbyte       = st_r.cshift;
            st_nxt.cstat.dir   = st_r.cshift[0];
            st_nxt.cstat.cause = 1'b1;
            st_nxt.cstat.frame = 1'b1;
          end else begin
            st_nxt.cst = C_IDLE;
          end
        end
      end
      C_AHOLD, C_DHOLD: begin
        if (ccmd_go) begin
          st_nxt.cstat.frame     = 1'b0;
          st_nxt.cstat.byte_flag = 1'b0;
          st_nxt.cbit            = 4'h0;
          if ((st_r.cst == C_DHOLD) & st_r.cstat.dir) begin
            st_nxt.cst       = C_RD;
            st_nxt.cshift    = st_r.cbyte;
            st_nxt.c_sda_low = ~st_r.cbyte[7];
          end else begin
            st_nxt.cst       = (st_r.cst == C_AHOLD) ? C_AACK : C_DACK;
            st_nxt.c_sda_low = ~HWDATA_IN[0];
          end
        end
      end
      C_AACK, C_DACK: begin
        if (scl_rise & st_r.c_rsel & ~st_r.sda_s) begin
          st_nxt.cst         = C_IDLE;
          st_nxt.cstat.clash = 1'b1;
          st_nxt.c_mute      = 1'b1;
          st_nxt.c_sda_low   = 1'b0;
        end else if (scl_fall) begin
          st_nxt.c_sda_low = 1'b0;
          st_nxt.cbit      = 4'h0;
          if (st_r.c_rsel) begin
            st_nxt.cst = C_IDLE;
          end else if ((st_r.cst == C_AACK) & st_r.cstat.dir) begin
            st_nxt.cst             = C_DHOLD;
            st_nxt.cstat.byte_flag = 1'b1;
          end else begin
            st_nxt.cst = C_WR;
          end
        end
      end
      C_RD: begin
        if (scl_rise & ~st_r.c_sda_low & ~st_r.sda_s) begin
          st_nxt.cst         = C_IDLE;
          st_nxt.cstat.clash = 1'b1;
          st_nxt.c_mute      = 1'b1;
        end else if (scl_rise) begin
          st_nxt.cbit = st_r.cbit + 4'h1;
        end else if (scl_fall & (st_r.cbit == BITS_BYTE)) begin
          st_nxt.cst       = C_RACK;
          st_nxt.c_sda_low = 1'b0;
        end else if (scl_fall) begin
          st_nxt.cshift    = {st_r.cshift[6:0], 1'b0};
          st_nxt.c_sda_low = ~st_r.cshift[6];
        end
      end
      C_RACK: begin
        if (scl_rise) begin
          st_nxt.cstat.rxack = st_r.sda_s;
        end else if (scl_fall & ~st_r.cstat.rxack) begin
          st_nxt.cst             = C_DHOLD;
          st_nxt.cstat.byte_flag = 1'b1;
        end else if (scl_fall) begin
          st_nxt.cst = C_IDLE;
        end
      end
      C_IDLE: st_nxt.c_sda_low = 1'b0;
      default: st_nxt.cst = C_IDLE;
    endcase

    // Start and Stop override the client engine; Start is taken even after a clash
    if (start_det) begin
      st_nxt.cst       = C_ADDR;
      st_nxt.cbit      = 4'h0;
      st_nxt.c_mute    = 1'b0;
      st_nxt.c_sda_low = 1'b0;
    end else if (stop_det) begin
      if ((st_r.cst == C_ADDR) & (st_r.cbit <= 4'h1)) begin
        st_nxt.cstat.fault = 1'b1;
      end else if ((st_r.cst != C_IDLE) & (st_r.cst != C_ADDR)) begin
        st_nxt.cstat.frame = 1'b1;
        st_nxt.cstat.cause = 1'b0;
      end
      st_nxt.cst       = C_IDLE;
      st_nxt.c_sda_low = 1'b0;
    end
    if (~st_r.ccta.en) begin
      st_nxt.cst       = C_IDLE;
      st_nxt.c_sda_low = 1'b0;
    end
    st_nxt.cstat.stretch = c_hold;
  end

  // state register
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // checks
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  property p_rx_flag_stretch;
    $rose(st_r.hstat.rx_flag) |-> st_r.hstat.stretch && !SCL_OE_N_OUT && st_r.hst == H_HELD;
  endproperty
  a_rx_flag_stretch: assert property (p_rx_flag_stretch)
    else $error("receive flag without stretch");

  property p_no_early_reply;
    st_r.hst == H_HELD |-> !st_r.h_sda_low;
  endproperty
  a_no_early_reply: assert property (p_no_early_reply)
    else $error("host reply driven before command");

  property p_reply_code;
    $rose(st_r.hst == H_ACK) |-> st_r.h_sda_low == !st_r.h_rsel;
  endproperty
  a_reply_code: assert property (p_reply_code)
    else $error("reply level does not follow select");

  property p_nack_loss;
    st_r.hst == H_ACK && st_r.hph && tick && st_r.h_rsel && !st_r.sda_s
      |=> st_r.hstat.arb && st_r.hstat.bus_state == BUS_BUSY && st_r.hst == H_IDLE;
  endproperty
  a_nack_loss: assert property (p_nack_loss)
    else $error("collision on reply not handled");

  property p_loss_done;
    $rose(st_r.hstat.arb) |-> st_r.hstat.tx_done && !st_r.h_scl_low && !st_r.h_sda_low;
  endproperty
  a_loss_done: assert property (p_loss_done)
    else $error("loss without tx done");

  property p_exclusive;
    !(st_r.hstat.rx_flag && st_r.hstat.tx_done);
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("rx and tx flags both set");

  property p_flag_holds_scl;
    ($rose(st_r.cstat.frame) && st_r.cstat.cause) || $rose(st_r.cstat.byte_flag)
      |-> !SCL_OE_N_OUT;
  endproperty
  a_flag_holds_scl: assert property (p_flag_holds_scl)
    else $error("client flag up but SCL released");

  property p_no_match;
    st_r.cst == C_ADDR && scl_fall && !start_det && !stop_det && st_r.cbit == BITS_BYTE
      && !addr_hit && st_r.ccta.en |=> st_r.cst == C_IDLE && $stable(st_r.cbyte);
  endproperty
  a_no_match: assert property (p_no_match)
    else $error("unmatched address changed state");

  property p_match;
    st_r.cst == C_ADDR && scl_fall && !start_det && !stop_det && st_r.cbit == BITS_BYTE
      && addr_hit && st_r.ccta.en && !(wr_en && reg_hit(st_r.dph_addr, OFF_CBYTE))
      |=> st_r.cstat.frame && st_r.cstat.cause && st_r.cbyte == $past(st_r.cshift);
  endproperty
  a_match: assert property (p_match)
    else $error("matched address not stored");

  property p_start_stop;
    st_r.cst == C_ADDR && st_r.cbit <= 4'h1 && stop_det && !start_det |=> st_r.cstat.fault;
  endproperty
  a_start_stop: assert property (p_start_stop)
    else $error("start then stop not faulted");

  property p_stop_cause;
    stop_det && !start_det && st_r.ccta.en && st_r.cst != C_IDLE && st_r.cst != C_ADDR
      |=> st_r.cstat.frame && !st_r.cstat.cause;
  endproperty
  a_stop_cause: assert property (p_stop_cause)
    else $error("stop not reported");

  property p_clash;
    $rose(st_r.cstat.clash) |-> st_r.c_mute && !c_hold ##1 SDA_OE_N_OUT || st_r.h_sda_low;
  endproperty
  a_clash: assert property (p_clash)
    else $error("clash left client driving");

endmodule

// file: sim/i2c_bus_partner.sv
// remote host and remote client model on the two-wire bus
`timescale 1ns/1ps
module i2c_bus_partner (
  // link clock and wire levels
  input  wire logic lclk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  // open-drain pulls, 1 = released
  output logic      scl_out,
  output logic      sda_out
);
  logic       sda_h = 1'b1, sda_c = 1'b1, cl_en = 1'b0, ack_lvl = 1'b1;
  logic [7:0] tx_byte = 8'h00;
  logic [3:0] cnt = 4'h0;
  initial scl_out = 1'b1;
  assign sda_out = sda_h & sda_c;
  // start: sda falls while scl high
  task automatic start();
    sda_h   <= 1'b1;
    scl_out <= 1'b1;
    @(posedge lclk_in);
    sda_h <= 1'b0;
    @(posedge lclk_in);
    scl_out <= 1'b0;
  endtask
  // one clock pulse, waits out stretching
  task automatic pulse(input logic v, output logic s);
    @(posedge lclk_in);
    sda_h <= v;
    @(posedge lclk_in);
    scl_out <= 1'b1;
    wait (scl_in);
    s = sda_in;
    @(posedge lclk_in);
    scl_out <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(b[i], s);
  endtask
  // stop: sda rises while scl high
  task automatic stop();
    @(posedge lclk_in);
    sda_h <= 1'b0;
    @(posedge lclk_in);
    scl_out <= 1'b1;
    wait (scl_in);
    @(posedge lclk_in);
    sda_h <= 1'b1;
  endtask
  // client answer to the host: msb first, ack level in ninth slot
  always @(negedge scl_in) begin
    if (cl_en) begin
      sda_c <= (cnt == 4'h8) ? ack_lvl : tx_byte[3'(4'h7 - cnt)];
      cnt   <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    end
  end
endmodule

// file: sim/i2c_rx_client_test.sv
// self-checking bench: client address modes and transfers, host receive
`timescale 1ns/1ps
module i2c_rx_client_test
  import i2c_rx_client_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, lclk = 1'b0, hsel = 1'b0, hwrite = 1'b0, b;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic        hrdy, hresp, scl_oe_n, sda_oe_n, scl_p, sda_p, scl_w, sda_w;
  logic [6:0]  id;
  logic [7:0]  a, d, prev;
  logic [1:0]  cd;
  int          err_total = 0, checks = 0, cyc = 0;
  assign scl_w = scl_oe_n & scl_p;
  assign sda_w = sda_oe_n & sda_p;
  always #5 clk = ~clk;
  always #80 lclk = ~lclk;
  i2c_rx_client dut (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hrdy), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp),
    .SCL_IN(scl_w), .SCL_OUT(), .SCL_OE_N_OUT(scl_oe_n), .SDA_IN(sda_w), .SDA_OUT(),
    .SDA_OE_N_OUT(sda_oe_n));
  i2c_bus_partner p (.lclk_in(lclk), .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_p),
    .sda_out(sda_p));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  // one single AHB-Lite transfer, read data left in q
  task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= ad;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  // expected low status nibble after an address byte; a miss keeps direction and cause
  function automatic logic [3:0] cexp(input logic m, input logic dr, input logic [1:0] dc);
    return m ? {dr, 3'b110} : {dc, 2'b00};
  endfunction
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h9d4f104f));
    id = 7'($urandom) | 7'h01;
    d = 8'($urandom);
    prev = 8'h00;
    cd = 2'b00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // own, miss, general call, second id, promiscuous
    for (int i = 0; i < 5; i++) begin
      a = (i == 0) ? {id, 1'b1} : (i == 1) ? {~id, 1'b1} : (i == 2) ? 8'h00 :
          (i == 3) ? {~id, 1'b0} : d;
      ahb(1'b1, OFF_TID, (i == 2) ? 32'h1 : {24'h0, id, 1'b0});
      ahb(1'b1, OFF_MASK, (i == 3) ? {24'h0, ~id, 1'b1} : 32'h0);
      ahb(1'b1, OFF_CCTLA, (i == 4) ? 32'h3 : 32'h1);
      p.start();
      p.send(a);
      repeat (40) @(posedge clk);
      ahb(1'b0, OFF_CSTAT, 0);
      chk("cstat", 32'(q[3:0]), 32'(cexp(i != 1, a[0], cd)));
      chk("hold", 32'(scl_oe_n), 32'(i == 1));
      if (i != 1) begin
        prev = a;
        cd   = {a[0], 1'b1};
      end
      ahb(1'b0, OFF_CBYTE, 0);
      chk("cbyte", q, 32'(prev));
      ahb(1'b1, OFF_CCTLB, 32'h3);
      p.pulse(1'b1, b);
      chk("nack", 32'(b), 1);
      p.stop();
      ahb(1'b1, OFF_CSTAT, 32'hFF);
    end
    // write transfer: ack, data byte, ack, stop, then start-stop
    ahb(1'b1, OFF_CCTLA, 32'h1);
    d = 8'($urandom);
    p.start();
    p.send({id, 1'b0});
    repeat (40) @(posedge clk);
    ahb(1'b1, OFF_CCTLB, 32'h2);
    p.pulse(1'b1, b);
    chk("ack", 32'(b), 0);
    p.send(d);
    repeat (40) @(posedge clk);
    ahb(1'b0, OFF_CSTAT, 0);
    chk("bytef", 32'(q[1:0]), 1);
    ahb(1'b0, OFF_CBYTE, 0);
    chk("data", q, 32'(d));
    ahb(1'b1, OFF_CCTLB, 32'h2);
    p.pulse(1'b1, b);
    chk("dack", 32'(b), 0);
    p.stop();
    repeat (40) @(posedge clk);
    ahb(1'b0, OFF_CSTAT, 0);
    chk("stop", 32'(q[2:1]), 1);
    ahb(1'b1, OFF_CSTAT, 32'hFF);
    p.start();
    p.stop();
    repeat (40) @(posedge clk);
    ahb(1'b0, OFF_CSTAT, 0);
    chk("fault", 32'(q[4]), 1);
    // client nack overridden by a low wire: clash, outputs released
    p.start();
    p.send({id, 1'b0});
    repeat (40) @(posedge clk);
    ahb(1'b1, OFF_CCTLB, 32'h3);
    p.pulse(1'b0, b);
    repeat (40) @(posedge clk);
    ahb(1'b0, OFF_CSTAT, 0);
    chk("clash", 32'({q[5], scl_oe_n, sda_oe_n}), 7);
    p.stop();
    ahb(1'b1, OFF_CSTAT, 32'hFF);
    // host receive: ack one byte, then a nack that clashes
    ahb(1'b1, OFF_CCTLA, 32'h0);
    p.tx_byte = d;
    p.cl_en = 1'b1;
    q = '0;
    ahb(1'b1, OFF_HCTLB, 32'h4);
    for (int k = 0; k < 2; k++) begin
      for (int t = 0; t < 4000 && q[0] !== 1'b1; t++) ahb(1'b0, OFF_HSTAT, 0);
      chk("hstat", 32'(q[2:0]), 5);
      chk("sda", 32'(sda_oe_n), 1);
      ahb(1'b0, OFF_HDATA, 0);
      chk("hdata", q, 32'(d));
      p.ack_lvl = 1'b0;
      ahb(1'b1, OFF_HCTLB, (k == 1) ? 32'h5 : 32'h4);
      ahb(1'b0, OFF_HSTAT, 0);
      chk("free", 32'(q[2:0]), 0);
      repeat (100) @(posedge clk);
      chk("reply", 32'(sda_oe_n), k);
      q = '0;
    end
    for (int t = 0; t < 600 && q[3] !== 1'b1; t++) ahb(1'b0, OFF_HSTAT, 0);
    chk("arb", 32'(q[6:0]), 32'h4A);
    chk("gone", 32'({scl_oe_n, sda_oe_n}), 3);
    conclude();
  end
endmodule
